// File: hw/pio_defs.svh
/*
  Register indices, field masks and reset values of the parallel I/O block.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// register indices, byte address is four times the index
`define PIO_IDX_FIRST_DATA 3'h0
`define PIO_IDX_SECOND_DATA 3'h1
`define PIO_IDX_THIRD_DATA 3'h2
`define PIO_IDX_FOURTH_DATA 3'h3
`define PIO_IDX_FIRST_DIR 3'h4
`define PIO_IDX_SECOND_DIR 3'h5
`define PIO_IDX_THIRD_DIR 3'h6
`define PIO_IDX_FOURTH_DIR 3'h7

// paddr layout
`define PIO_ADDR_IDX_LSB 2
`define PIO_ADDR_IDX_MSB 4
`define PIO_ADDR_ALIGN 2'h0

// implemented bits: latch and direction storage
`define PIO_FIRST_DIR_MASK 8'hff
`define PIO_SECOND_DIR_MASK 8'he0
`define PIO_THIRD_DIR_MASK 8'hff
`define PIO_FOURTH_DIR_MASK 8'h20
// implemented bits: pin level readable
`define PIO_FIRST_IN_MASK 8'hff
`define PIO_SECOND_IN_MASK 8'he0
`define PIO_THIRD_IN_MASK 8'hff
`define PIO_FOURTH_IN_MASK 8'ha0

`define PIO_DIR_RESET 8'h00
`define PIO_RDATA_RESET 32'h0000_0000
`define PIO_UPPER_ZERO 24'h00_0000

`endif

// File: hw/pio_pkg.sv
/*
  Types shared by the parallel I/O block.
  Assumes nothing of its surroundings.
*/
package pio_pkg;

  typedef logic [7:0] pio_byte_t;

  // one-hot register select decoded from the bus address
  typedef enum logic [7:0] {
    PIO_SEL_FIRST_DATA = 8'h01,
    PIO_SEL_SECOND_DATA = 8'h02,
    PIO_SEL_THIRD_DATA = 8'h04,
    PIO_SEL_FOURTH_DATA = 8'h08,
    PIO_SEL_FIRST_DIR = 8'h10,
    PIO_SEL_SECOND_DIR = 8'h20,
    PIO_SEL_THIRD_DIR = 8'h40,
    PIO_SEL_FOURTH_DIR = 8'h80
  } pio_sel_t;

endpackage

// File: hw/pio_port.sv
/*
  One parallel port: output latch, direction register, read mux.
  Assumes write strobes are single-cycle pulses from the bus slave and
  pin levels are synchronous to sys_clk.
*/
`timescale 1ns/10ps
`include "pio_defs.svh"

module pio_port #(
  parameter logic [7:0] DIR_MASK = 8'hff,
  parameter logic [7:0] IN_MASK = 8'hff
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register access
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire pio_pkg::pio_byte_t wdata,
  output pio_pkg::pio_byte_t rd_data,
  output pio_pkg::pio_byte_t rd_dir,
  // pins
  input wire pio_pkg::pio_byte_t pin_in,
  output pio_pkg::pio_byte_t pin_out,
  output pio_pkg::pio_byte_t pin_oe
);

  pio_pkg::pio_byte_t latch_ff;
  pio_pkg::pio_byte_t dir_ff;

  ////////////////////////////////////////////////////////////////////////////
  // output latch: written whatever the direction, untouched by reset
  always_ff @(posedge sys_clk)
  begin
    if (wr_data)
    begin
      latch_ff <= wdata & DIR_MASK;
    end
  end

  // direction: only implemented bits, cleared to input on reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dir_ff <= `PIO_DIR_RESET;
    end
    else if (wr_dir)
    begin
      dir_ff <= wdata & DIR_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output mode reads the latch, input mode reads the pin
  assign rd_data = (dir_ff & latch_ff)
    | (~dir_ff & pin_in & IN_MASK);
  assign rd_dir = dir_ff;
  // absent bits show low even before the first write
  assign pin_out = latch_ff & DIR_MASK;
  assign pin_oe = dir_ff;

endmodule

// File: hw/pio_top.sv
/*
  Parallel I/O block: four ports behind an APB slave.
  Assumes an APB master on sys_clk and pin levels already synchronous
  to sys_clk; the pad logic resolves pin_out and pin_oe into the wire.
*/
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "pio_defs.svh"

module pio_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // first port pins
  input wire logic [7:0] first_port_pins_in,
  output logic [7:0] first_port_pins_out,
  output logic [7:0] first_port_pins_oe,
  // second port pins, bits 7 to 5 used
  input wire logic [7:0] second_port_pins_in,
  output logic [7:0] second_port_pins_out,
  output logic [7:0] second_port_pins_oe,
  // third port pins
  input wire logic [7:0] third_port_pins_in,
  output logic [7:0] third_port_pins_out,
  output logic [7:0] third_port_pins_oe,
  // fourth port pins, bit 5 two-way, bit 7 input only
  input wire logic [7:0] fourth_port_pins_in,
  output logic [7:0] fourth_port_pins_out,
  output logic [7:0] fourth_port_pins_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic [2:0] reg_idx;
  logic addr_ok;
  pio_pkg::pio_sel_t reg_sel;
  logic [7:0] sel_vec;
  logic acc_wr;
  logic wr_lane;

  assign reg_idx = paddr[`PIO_ADDR_IDX_MSB:`PIO_ADDR_IDX_LSB];
  assign addr_ok = (paddr[1:0] == `PIO_ADDR_ALIGN)
    && (paddr[ADDR_W-1:`PIO_ADDR_IDX_MSB+1] == '0);

  always_comb
  begin
    case (reg_idx)
      `PIO_IDX_FIRST_DATA: reg_sel = pio_pkg::PIO_SEL_FIRST_DATA;
      `PIO_IDX_SECOND_DATA: reg_sel = pio_pkg::PIO_SEL_SECOND_DATA;
      `PIO_IDX_THIRD_DATA: reg_sel = pio_pkg::PIO_SEL_THIRD_DATA;
      `PIO_IDX_FOURTH_DATA: reg_sel = pio_pkg::PIO_SEL_FOURTH_DATA;
      `PIO_IDX_FIRST_DIR: reg_sel = pio_pkg::PIO_SEL_FIRST_DIR;
      `PIO_IDX_SECOND_DIR: reg_sel = pio_pkg::PIO_SEL_SECOND_DIR;
      `PIO_IDX_THIRD_DIR: reg_sel = pio_pkg::PIO_SEL_THIRD_DIR;
      `PIO_IDX_FOURTH_DIR: reg_sel = pio_pkg::PIO_SEL_FOURTH_DIR;
      default: reg_sel = pio_pkg::PIO_SEL_FIRST_DATA;
    endcase
  end

  // write takes effect at the edge that ends the access phase
  assign wr_lane = pstrb[0];
  assign acc_wr = psel && penable && pwrite && addr_ok && wr_lane;
  assign sel_vec = acc_wr ? reg_sel : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // the four ports
  pio_pkg::pio_byte_t rd_data [4];
  pio_pkg::pio_byte_t rd_dir [4];
  pio_pkg::pio_byte_t wbyte;

  assign wbyte = pwdata[7:0];

  pio_port #(
    .DIR_MASK(`PIO_FIRST_DIR_MASK),
    .IN_MASK(`PIO_FIRST_IN_MASK)
  ) u_first (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_data(sel_vec[0]),
    .wr_dir(sel_vec[4]),
    .wdata(wbyte),
    .rd_data(rd_data[0]),
    .rd_dir(rd_dir[0]),
    .pin_in(first_port_pins_in),
    .pin_out(first_port_pins_out),
    .pin_oe(first_port_pins_oe)
  );

  pio_port #(
    .DIR_MASK(`PIO_SECOND_DIR_MASK),
    .IN_MASK(`PIO_SECOND_IN_MASK)
  ) u_second (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_data(sel_vec[1]),
    .wr_dir(sel_vec[5]),
    .wdata(wbyte),
    .rd_data(rd_data[1]),
    .rd_dir(rd_dir[1]),
    .pin_in(second_port_pins_in),
    .pin_out(second_port_pins_out),
    .pin_oe(second_port_pins_oe)
  );

  pio_port #(
    .DIR_MASK(`PIO_THIRD_DIR_MASK),
    .IN_MASK(`PIO_THIRD_IN_MASK)
  ) u_third (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_data(sel_vec[2]),
    .wr_dir(sel_vec[6]),
    .wdata(wbyte),
    .rd_data(rd_data[2]),
    .rd_dir(rd_dir[2]),
    .pin_in(third_port_pins_in),
    .pin_out(third_port_pins_out),
    .pin_oe(third_port_pins_oe)
  );

  pio_port #(
    .DIR_MASK(`PIO_FOURTH_DIR_MASK),
    .IN_MASK(`PIO_FOURTH_IN_MASK)
  ) u_fourth (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_data(sel_vec[3]),
    .wr_dir(sel_vec[7]),
    .wdata(wbyte),
    .rd_data(rd_data[3]),
    .rd_dir(rd_dir[3]),
    .pin_in(fourth_port_pins_in),
    .pin_out(fourth_port_pins_out),
    .pin_oe(fourth_port_pins_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data: captured in the setup cycle, shown in the access phase
  pio_pkg::pio_byte_t rd_byte;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  always_comb
  begin
    case (reg_sel)
      pio_pkg::PIO_SEL_FIRST_DATA: rd_byte = rd_data[0];
      pio_pkg::PIO_SEL_SECOND_DATA: rd_byte = rd_data[1];
      pio_pkg::PIO_SEL_THIRD_DATA: rd_byte = rd_data[2];
      pio_pkg::PIO_SEL_FOURTH_DATA: rd_byte = rd_data[3];
      pio_pkg::PIO_SEL_FIRST_DIR: rd_byte = rd_dir[0];
      pio_pkg::PIO_SEL_SECOND_DIR: rd_byte = rd_dir[1];
      pio_pkg::PIO_SEL_THIRD_DIR: rd_byte = rd_dir[2];
      pio_pkg::PIO_SEL_FOURTH_DIR: rd_byte = rd_dir[3];
      default: rd_byte = '0;
    endcase
    nxt_prdata = addr_ok ? {`PIO_UPPER_ZERO, rd_byte} : `PIO_RDATA_RESET;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata_ff <= `PIO_RDATA_RESET;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;
  // no wait states: every access ends at its first access-phase edge
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  logic setup_rd;
  assign setup_rd = psel && !penable && !pwrite && addr_ok;

  a_dir_reset_clear: assert property (
    @(posedge sys_clk) $rose(nrst) |->
      (first_port_pins_oe == '0) && (second_port_pins_oe == '0)
      && (third_port_pins_oe == '0) && (fourth_port_pins_oe == '0))
    else $error("direction not cleared by reset");

  a_latch_keep_reset: assert property (
    @(posedge sys_clk) !nrst && $past(!nrst) |->
      $stable(third_port_pins_out))
    else $error("output latch changed during reset");

  a_oe_follows_dir: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    acc_wr && reg_idx == `PIO_IDX_FIRST_DIR |=>
      first_port_pins_oe == $past(pwdata[7:0]))
    else $error("first port enables do not follow direction write");

  a_latch_any_dir: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    acc_wr && reg_idx == `PIO_IDX_THIRD_DATA |=>
      third_port_pins_out == $past(pwdata[7:0]))
    else $error("data write did not reach the latch");

  a_read_out_latch: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    setup_rd && reg_idx == `PIO_IDX_FIRST_DATA
      && first_port_pins_oe == 8'hff |=>
      prdata[7:0] == first_port_pins_out)
    else $error("output-mode read did not return latch");

  a_read_in_pin: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    setup_rd && reg_idx == `PIO_IDX_THIRD_DATA
      && third_port_pins_oe == 8'h00 |=>
      prdata[7:0] == $past(third_port_pins_in))
    else $error("input-mode read did not return pin level");

  a_single_cycle: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    psel && !penable |=> !(psel && penable) || pready)
    else $error("access phase was stretched");

  a_second_low_bits: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (second_port_pins_oe[4:0] == '0) && (second_port_pins_out[4:0] == '0))
    else $error("second port drives an unimplemented bit");

  a_fourth_no_drv: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (fourth_port_pins_oe & ~`PIO_FOURTH_DIR_MASK) == '0)
    else $error("fourth port drives an input-only or absent bit");

  a_data_decode: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    acc_wr && reg_idx == `PIO_IDX_SECOND_DATA |=>
      second_port_pins_out[7:5] == $past(pwdata[7:5])
      && $stable(first_port_pins_out))
    else $error("data write decoded to the wrong port");

  a_bad_addr_kept: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    psel && penable && pwrite && !addr_ok |=>
      $stable(first_port_pins_out) && $stable(first_port_pins_oe))
    else $error("write to a bad address changed a port");

  a_strobe_gate: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    psel && penable && pwrite && !wr_lane |=>
      $stable(first_port_pins_out))
    else $error("write without its byte strobe reached a latch");

  a_fourth_in_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    setup_rd && reg_idx == `PIO_IDX_FOURTH_DATA |=>
      prdata[7] == $past(fourth_port_pins_in[7]))
    else $error("input-only bit did not read the pin");

  a_second_dir_read: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    setup_rd && reg_idx == `PIO_IDX_SECOND_DIR |=>
      prdata[7:0] == $past(second_port_pins_oe))
    else $error("second port direction read is wrong");

  c_write_then_output: cover property (
    @(posedge sys_clk) disable iff (!nrst)
    acc_wr && reg_idx == `PIO_IDX_FIRST_DATA ##[1:20]
      acc_wr && reg_idx == `PIO_IDX_FIRST_DIR);

  c_read_input: cover property (
    @(posedge sys_clk) disable iff (!nrst)
    setup_rd && reg_idx == `PIO_IDX_FOURTH_DATA);

  c_bad_addr: cover property (
    @(posedge sys_clk) disable iff (!nrst)
    pslverr);

  c_read_output: cover property (
    @(posedge sys_clk) disable iff (!nrst)
    setup_rd && reg_idx == `PIO_IDX_FIRST_DATA
      && first_port_pins_oe == 8'hff);

endmodule

// File: verif/pio_pin_model.sv
/*
  Far-side model of the port pins: external drivers and the pad level.
  Assumes the bench sets ext and fight; oe high means the block drives.
*/
`timescale 1ns/10ps

module pio_pin_model (
  // block side
  input wire logic [31:0] drv,
  input wire logic [31:0] oe,
  // external side
  input wire logic [31:0] ext,
  input wire logic fight,
  output logic [31:0] lvl
);
  // fight lets a strong external driver win against the block
  assign lvl = fight ? ext : ((oe & drv) | (~oe & ext));
endmodule

// File: verif/tb_pio_top.sv
/*
  Self-checking bench of the parallel I/O block over APB.
  Assumes hw/ on the include path and the pin model compiled first.
*/
`timescale 1ns/10ps
`include "pio_defs.svh"

module tb_pio_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] ext = 32'h0;
  logic fight = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdat;
  logic rerr;
  wire [31:0] pin_lvl;
  wire [31:0] pin_drv;
  wire [31:0] pin_oe;
  int bad_count = 0;
  int checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  pio_top uut (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_port_pins_in(pin_lvl[7:0]),
    .first_port_pins_out(pin_drv[7:0]),
    .first_port_pins_oe(pin_oe[7:0]),
    .second_port_pins_in(pin_lvl[15:8]),
    .second_port_pins_out(pin_drv[15:8]),
    .second_port_pins_oe(pin_oe[15:8]),
    .third_port_pins_in(pin_lvl[23:16]),
    .third_port_pins_out(pin_drv[23:16]),
    .third_port_pins_oe(pin_oe[23:16]),
    .fourth_port_pins_in(pin_lvl[31:24]),
    .fourth_port_pins_out(pin_drv[31:24]),
    .fourth_port_pins_oe(pin_oe[31:24])
  );

  pio_pin_model pins_far (
    .drv(pin_drv), .oe(pin_oe), .ext(ext), .fight(fight), .lvl(pin_lvl)
  );

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
  begin
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
  begin
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input string what, input logic [7:0] a,
    input logic [31:0] exp);
  begin
    apb(1'b0, a, 32'h0, 4'hf);
    chk(what, exp, rdat);
    chk("pslverr", 32'h0, {31'h0, rerr});
  end
  endtask

  // pins are looked at mid-cycle, after the write edge has landed
  task automatic pins(input logic [31:0] o, input logic [31:0] e);
  begin
    @(negedge sys_clk);
    chk("pins_out", o, pin_drv);
    chk("pins_oe", e, pin_oe);
    // back on the rising edge, where the bench drives inputs
    @(posedge sys_clk);
  end
  endtask

  task automatic give_verdict;
  begin
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd("dir", 8'h10 + 8'(4 * i), 32'h0);
    chk("oe", 32'h0, pin_oe);
    wr(8'h00, 32'ha5);
    wr(8'h04, 32'hff);
    wr(8'h08, 32'h3c);
    wr(8'h0c, 32'hff);
    pins(32'h203ce0a5, 32'h0);
    ext <= 32'hff0fa05a;
    rd("first", 8'h00, 32'h5a);
    rd("second", 8'h04, 32'ha0);
    rd("third", 8'h08, 32'h0f);
    rd("fourth", 8'h0c, 32'ha0);
    for (int i = 0; i < 4; i++)
      wr(8'h10 + 8'(4 * i), 32'hff);
    rd("dir1", 8'h10, {24'h0, `PIO_FIRST_DIR_MASK});
    rd("dir2", 8'h14, {24'h0, `PIO_SECOND_DIR_MASK});
    rd("dir3", 8'h18, {24'h0, `PIO_THIRD_DIR_MASK});
    rd("dir4", 8'h1c, {24'h0, `PIO_FOURTH_DIR_MASK});
    pins(32'h203ce0a5, 32'h20ffe0ff);
    fight <= 1'b1;
    ext <= 32'h0;
    rd("first", 8'h00, 32'ha5);
    rd("second", 8'h04, 32'he0);
    rd("third", 8'h08, 32'h3c);
    rd("fourth", 8'h0c, 32'h20);
    ext <= 32'h800000f0;
    wr(8'h10, 32'h0f);
    rd("first mix", 8'h00, 32'hf5);
    rd("fourth mix", 8'h0c, 32'ha0);
    apb(1'b1, 8'h00, 32'h0, 4'h0);
    pins(32'h203ce0a5, 32'h20ffe00f);
    apb(1'b0, 8'h20, 32'h0, 4'hf);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b1, 8'h01, 32'h0, 4'hf);
    chk("misaligned err", 32'h1, {31'h0, rerr});
    pins(32'h203ce0a5, 32'h20ffe00f);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pins(32'h203ce0a5, 32'h0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    rd("dir after reset", 8'h14, 32'h0);
    give_verdict;
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    give_verdict;
  end
endmodule
